// file: hw/uss_consts.svh
// Purpose: constants for the uart status and shadow register block
// Assumes: axi4-lite, 32-bit data, byte addresses as printed
// Notes: all offsets, fields, reset values and counts live here
//
// Behaviour
// - status bit 1 reads 1 while transmit fifo not full; resets to 1.
// - status bit 0 set while a serial transfer is in progress.
// - transmit fifo fill count readable as 5 bits; resets to zero.
// - receive fifo fill count readable as 5 bits; resets to zero.
// - soft reset bit 2 flushes transmit fifo; no effect without fifo.
// - soft reset bit 1 flushes receive fifo like the control reset bit.
// - soft reset bit 0 resets whole uart; release synchronised to clock.
// - shadow request-to-send shares storage with modem control bit.
// - shadow break shares storage with line control break bit.
// - shadow dma select mirrors fifo control dma mode bit.
// - shadow fifo enable mirrors fifo control enable bit.
// - shadow receive threshold mirrors 2-bit fifo control receive trigger.
// - shadow empty threshold mirrors trigger; writes ignored without programmable empty.
// - halt bit suspends transmission; writes ignored without fifo.
// - dma soft acknowledge write ends dma transfer; ignored without extra dma.
// - status bit 2 reads 1 while transmit fifo empty; resets to 1.
// - status bit 4 reads 1 while receive fifo completely full.
`ifndef USS_CONSTS_SVH
`define USS_CONSTS_SVH

// ********************************
// register offsets
// ********************************
`define USS_ADDR_W 8
`define USS_OFF_STATUS 8'h7C
`define USS_OFF_TX_LVL 8'h80
`define USS_OFF_RX_LVL 8'h84
`define USS_OFF_SRST 8'h88
`define USS_OFF_SHADOW_REQ_TO_SEND 8'h8C
`define USS_OFF_SBRK 8'h90
`define USS_OFF_SDMA 8'h94
`define USS_OFF_SFEN 8'h98
`define USS_OFF_SRXT 8'h9C
`define USS_OFF_STXT 8'hA0
`define USS_OFF_HALT 8'hA4
`define USS_OFF_DMA_SOFT_ACK 8'hA8
`define USS_OFF_PARAM 8'hF4
`define USS_OFF_IRQ_STAT 8'hE0
`define USS_OFF_IRQ_MASK 8'hE4

// ********************************
// field positions
// ********************************
`define USS_ST_BUSY 0
`define USS_ST_TNF 1
`define USS_ST_TFE 2
`define USS_ST_RNE 3
`define USS_ST_RFF 4
`define USS_SR_UR 0
`define USS_SR_RFR 1
`define USS_SR_XFR 2
`define USS_PRM_EXTRA_DMA 13
`define USS_PRM_THRE 5
`define USS_PRM_STAT 10
`define USS_PRM_SHADOW 11
`define USS_PRM_FIFO_LO 16
`define USS_FIFO_MODE_16 8'h01
`define USS_IRQ_N 3
`define USS_IRQ_TXE 0
`define USS_IRQ_RXF 1
`define USS_IRQ_DMA_SOFT_ACK 2

// ********************************
// reset values and counts
// ********************************
`define USS_LVL_W 5
`define USS_FIFO_DEPTH 5'h10
`define USS_STATUS_RST 5'h06
`define USS_RST_SYNC_N 2

`endif

// file: hw/uss_pkg.sv
// Purpose: types for the uart status and shadow register block
// Assumes: used with uss_consts.svh
// Notes: no constants here, only types
package uss_pkg;
	// gray sequence idle -> answer
	typedef enum logic [1:0] {USS_IDLE = 2'b00, USS_RESP = 2'b01} uss_bus_st_t;
endpackage

// file: hw/uss_regs.sv
// Purpose: status, fifo level, soft reset and shadow control registers of a uart
// Assumes: axi4-lite slave on mclk_i; fifo and line state from the uart core
// Notes: one write and one read may run in parallel; read answers one cycle after take, write answers two cycles after
//
// Implementation choice: the AXI4-Lite register port.
`include "uss_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module uss_regs #(
	parameter bit HAS_FIFO = 1'b1,
	parameter bit HAS_THRE_USER = 1'b1,
	parameter bit HAS_EXTRA_DMA = 1'b1
)(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// axi4-lite write
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	// axi4-lite read
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	// uart core state, same clock
	input wire logic [4:0] tx_fifo_level_i,
	input wire logic [4:0] rx_fifo_level_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	// main control views written by the core register file
	input wire logic main_wr_rts_i,
	input wire logic main_wr_brk_i,
	input wire logic main_wr_fcr_i,
	input wire logic [7:0] main_wdata_i,
	// control outputs to the uart core
	output logic req_to_send_o,
	output logic break_ctl_o,
	output logic dma_select_o,
	output logic fifo_on_o,
	output logic [1:0] rx_threshold_o,
	output logic [1:0] tx_empty_threshold_o,
	output logic tx_halt_o,
	output logic tx_fifo_flush_o,
	output logic rx_fifo_flush_o,
	output logic uart_full_reset_o,
	output logic dma_soft_ack_o,
	output logic irq_o
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		uss_pkg::uss_bus_st_t wst;
		uss_pkg::uss_bus_st_t rst;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rts;
		logic brk;
		logic dma;
		logic fen;
		logic [1:0] rxt;
		logic [1:0] txt;
		logic halt;
		logic txflush;
		logic rxflush;
		logic dma_soft_ack;
		logic [1:0] ur_sync;
		logic [4:0] stat;
		logic [4:0] tlvl;
		logic [4:0] rlvl;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic tfe_d;
		logic rff_d;
		logic irq;
		logic awrdy;
		logic wrdy;
		logic bvld;
		logic arrdy;
		logic rvld;
		logic urst;
	} uss_state_t;

	uss_state_t s_r;
	uss_state_t s_nxt;

	// ********************************
	// decode
	// ********************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = 1'b1;
		if (a == `USS_OFF_STATUS) is_mapped = 1'b1;
		else if (a >= `USS_OFF_TX_LVL && a <= `USS_OFF_DMA_SOFT_ACK && a[1:0] == 2'b00) is_mapped = 1'b1;
		else if (a == `USS_OFF_PARAM || a == `USS_OFF_IRQ_STAT || a == `USS_OFF_IRQ_MASK) is_mapped = 1'b1;
		else is_mapped = 1'b0;
	endfunction

	logic [31:0] param_word;
	logic [31:0] rd_word;
	logic w_fire;
	logic [2:0] ev;

	always_comb
	begin
		param_word = 32'h0000_0000;
		param_word[`USS_PRM_FIFO_LO +: 8] = HAS_FIFO ? `USS_FIFO_MODE_16 : 8'h00;
		param_word[`USS_PRM_EXTRA_DMA] = HAS_EXTRA_DMA;
		param_word[`USS_PRM_THRE] = HAS_THRE_USER;
		param_word[`USS_PRM_STAT] = 1'b1;
		param_word[`USS_PRM_SHADOW] = 1'b1;
		rd_word = 32'h0000_0000;
		if (s_araddr_i == `USS_OFF_STATUS) rd_word[4:0] = s_r.stat;
		else if (s_araddr_i == `USS_OFF_TX_LVL) rd_word[4:0] = s_r.tlvl;
		else if (s_araddr_i == `USS_OFF_RX_LVL) rd_word[4:0] = s_r.rlvl;
		else if (s_araddr_i == `USS_OFF_SHADOW_REQ_TO_SEND) rd_word[0] = s_r.rts;
		else if (s_araddr_i == `USS_OFF_SBRK) rd_word[0] = s_r.brk;
		else if (s_araddr_i == `USS_OFF_SDMA) rd_word[0] = s_r.dma;
		else if (s_araddr_i == `USS_OFF_SFEN) rd_word[0] = s_r.fen;
		else if (s_araddr_i == `USS_OFF_SRXT) rd_word[1:0] = s_r.rxt;
		else if (s_araddr_i == `USS_OFF_STXT) rd_word[1:0] = s_r.txt;
		else if (s_araddr_i == `USS_OFF_HALT) rd_word[0] = s_r.halt;
		else if (s_araddr_i == `USS_OFF_PARAM) rd_word = param_word;
		else if (s_araddr_i == `USS_OFF_IRQ_STAT) rd_word[2:0] = s_r.irq_st;
		else if (s_araddr_i == `USS_OFF_IRQ_MASK) rd_word[2:0] = s_r.irq_mask;
		else rd_word = 32'h0000_0000;
	end

	// ********************************
	// next state
	// ********************************
	always_comb
	begin
		s_nxt = s_r;
		w_fire = 1'b0;
		ev = 3'h0;
		// ********************************
		// one-cycle pulses
		// ********************************
		s_nxt.txflush = 1'b0;
		s_nxt.rxflush = 1'b0;
		s_nxt.dma_soft_ack = 1'b0;
		// ********************************
		// status sampled from the core
		// ********************************
		// one cycle of latency, traded for a flop-clean read mux
		s_nxt.stat = 5'h00;
		s_nxt.stat[`USS_ST_BUSY] = tx_active_i | rx_active_i;
		s_nxt.stat[`USS_ST_TNF] = tx_fifo_level_i != `USS_FIFO_DEPTH;
		s_nxt.stat[`USS_ST_TFE] = tx_fifo_level_i == 5'h00;
		s_nxt.stat[`USS_ST_RNE] = rx_fifo_level_i != 5'h00;
		s_nxt.stat[`USS_ST_RFF] = rx_fifo_level_i == `USS_FIFO_DEPTH;
		s_nxt.tlvl = tx_fifo_level_i;
		s_nxt.rlvl = rx_fifo_level_i;
		// main views share storage, so no second copy can drift
		if (main_wr_rts_i) s_nxt.rts = main_wdata_i[1];
		if (main_wr_brk_i) s_nxt.brk = main_wdata_i[6];
		if (main_wr_fcr_i)
		begin
			s_nxt.fen = main_wdata_i[0];
			s_nxt.rxflush = main_wdata_i[1] & HAS_FIFO;
			s_nxt.txflush = main_wdata_i[2] & HAS_FIFO;
			s_nxt.dma = main_wdata_i[3];
			if (HAS_THRE_USER) s_nxt.txt = main_wdata_i[5:4];
			s_nxt.rxt = main_wdata_i[7:6];
		end
		// ********************************
		// write channel
		// ********************************
		case (s_r.wst)
			uss_pkg::USS_IDLE:
			begin
				if (s_awvalid_i && !s_r.aw_got)
				begin
					s_nxt.aw_got = 1'b1;
					s_nxt.awaddr = s_awaddr_i;
				end
				if (s_wvalid_i && !s_r.w_got)
				begin
					s_nxt.w_got = 1'b1;
					s_nxt.wdata = s_wdata_i;
					s_nxt.wstrb = s_wstrb_i;
				end
				// both halves held: commit and answer on the same edge
				if (s_r.aw_got && s_r.w_got)
				begin
					w_fire = s_r.wstrb[0];
					s_nxt.aw_got = 1'b0;
					s_nxt.w_got = 1'b0;
					s_nxt.wst = uss_pkg::USS_RESP;
					s_nxt.bresp = is_mapped(s_r.awaddr) ? 2'b00 : 2'b10;
				end
			end
			uss_pkg::USS_RESP:
			begin
				if (s_bready_i)
					s_nxt.wst = uss_pkg::USS_IDLE;
			end
			default:
			begin
				s_nxt.wst = uss_pkg::USS_IDLE;
			end
		endcase
		if (w_fire)
		begin
			if (s_r.awaddr == `USS_OFF_SRST)
			begin
				s_nxt.txflush = s_r.wdata[`USS_SR_XFR] & HAS_FIFO;
				s_nxt.rxflush = s_r.wdata[`USS_SR_RFR] & HAS_FIFO;
			end
			else if (s_r.awaddr == `USS_OFF_SHADOW_REQ_TO_SEND) s_nxt.rts = s_r.wdata[0];
			else if (s_r.awaddr == `USS_OFF_SBRK) s_nxt.brk = s_r.wdata[0];
			else if (s_r.awaddr == `USS_OFF_SDMA) s_nxt.dma = s_r.wdata[0];
			else if (s_r.awaddr == `USS_OFF_SFEN) s_nxt.fen = s_r.wdata[0];
			else if (s_r.awaddr == `USS_OFF_SRXT) s_nxt.rxt = s_r.wdata[1:0];
			else if (s_r.awaddr == `USS_OFF_STXT && HAS_THRE_USER) s_nxt.txt = s_r.wdata[1:0];
			else if (s_r.awaddr == `USS_OFF_HALT && HAS_FIFO) s_nxt.halt = s_r.wdata[0];
			else if (s_r.awaddr == `USS_OFF_DMA_SOFT_ACK) s_nxt.dma_soft_ack = s_r.wdata[0] & HAS_EXTRA_DMA;
			else if (s_r.awaddr == `USS_OFF_IRQ_STAT) s_nxt.irq_st = s_r.irq_st & ~s_r.wdata[2:0];
			else if (s_r.awaddr == `USS_OFF_IRQ_MASK) s_nxt.irq_mask = s_r.wdata[2:0];
		end
		// ********************************
		// read channel
		// ********************************
		case (s_r.rst)
			uss_pkg::USS_IDLE:
			begin
				if (s_arvalid_i)
				begin
					s_nxt.rdata = rd_word;
					s_nxt.rresp = is_mapped(s_araddr_i) ? 2'b00 : 2'b10;
					s_nxt.rst = uss_pkg::USS_RESP;
				end
			end
			uss_pkg::USS_RESP:
			begin
				if (s_rready_i)
					s_nxt.rst = uss_pkg::USS_IDLE;
			end
			default:
			begin
				s_nxt.rst = uss_pkg::USS_IDLE;
			end
		endcase
		// ********************************
		// interrupt events
		// ********************************
		// set wins over a clear in the same cycle
		s_nxt.tfe_d = s_r.stat[`USS_ST_TFE];
		s_nxt.rff_d = s_r.stat[`USS_ST_RFF];
		ev[`USS_IRQ_TXE] = s_r.stat[`USS_ST_TFE] & ~s_r.tfe_d;
		ev[`USS_IRQ_RXF] = s_r.stat[`USS_ST_RFF] & ~s_r.rff_d;
		ev[`USS_IRQ_DMA_SOFT_ACK] = s_r.dma_soft_ack;
		s_nxt.irq_st = s_nxt.irq_st | ev;
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
		// ********************************
		// full reset pulse
		// ********************************
		// reset release follows the clock through a short chain
		s_nxt.ur_sync = {s_r.ur_sync[0], 1'b0};
		if (w_fire && s_r.awaddr == `USS_OFF_SRST && s_r.wdata[`USS_SR_UR]) s_nxt.ur_sync = 2'b11;
		// ********************************
		// output flops
		// ********************************
		// computed from next state so every port leaves a flop with no added latency
		s_nxt.awrdy = (s_nxt.wst == uss_pkg::USS_IDLE) & ~s_nxt.aw_got;
		s_nxt.wrdy = (s_nxt.wst == uss_pkg::USS_IDLE) & ~s_nxt.w_got;
		s_nxt.bvld = s_nxt.wst == uss_pkg::USS_RESP;
		s_nxt.arrdy = s_nxt.rst == uss_pkg::USS_IDLE;
		s_nxt.rvld = s_nxt.rst == uss_pkg::USS_RESP;
		// held two cycles so the core sees a clean, clock-aligned release
		s_nxt.urst = s_nxt.ur_sync[1] | s_nxt.ur_sync[0];
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
			s_r.stat <= `USS_STATUS_RST;
			// empty fifo out of reset is no fresh event
			s_r.tfe_d <= 1'b1;
			s_r.awrdy <= 1'b1;
			s_r.wrdy <= 1'b1;
			s_r.arrdy <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// ********************************
	// outputs
	// ********************************
	assign s_awready_o = s_r.awrdy;
	assign s_wready_o = s_r.wrdy;
	assign s_bvalid_o = s_r.bvld;
	assign s_bresp_o = s_r.bresp;
	assign s_arready_o = s_r.arrdy;
	assign s_rvalid_o = s_r.rvld;
	assign s_rdata_o = s_r.rdata;
	assign s_rresp_o = s_r.rresp;
	assign req_to_send_o = s_r.rts;
	assign break_ctl_o = s_r.brk;
	assign dma_select_o = s_r.dma;
	assign fifo_on_o = s_r.fen;
	assign rx_threshold_o = s_r.rxt;
	assign tx_empty_threshold_o = s_r.txt;
	assign tx_halt_o = s_r.halt;
	assign tx_fifo_flush_o = s_r.txflush;
	assign rx_fifo_flush_o = s_r.rxflush;
	assign uart_full_reset_o = s_r.urst;
	assign dma_soft_ack_o = s_r.dma_soft_ack;
	assign irq_o = s_r.irq;

endmodule

`default_nettype wire

// file: verif/uss_regs_properties.sv
// Purpose: port checks for the status and shadow register block
// Assumes: one clock, synchronous active-high reset
// Notes: main-view writes never meet a bus write to the same field
`timescale 1ns/1ps
`default_nettype none
module uss_regs_properties (
	// clock and reset
	input wire logic mclk_i, rst_i,
	// register bus
	input wire logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o, s_bready_i,
	input wire logic s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i,
	input wire logic [1:0] s_bresp_o,
	input wire logic [31:0] s_rdata_o,
	// control views
	input wire logic main_wr_rts_i, main_wr_brk_i, main_wr_fcr_i,
	input wire logic [7:0] main_wdata_i,
	input wire logic req_to_send_o, break_ctl_o, fifo_on_o, dma_select_o, tx_halt_o,
	input wire logic [1:0] rx_threshold_o,
	input wire logic tx_fifo_flush_o, rx_fifo_flush_o, uart_full_reset_o, dma_soft_ack_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ****************
	// properties
	// ****************
	sequence s_ur_two;
		uart_full_reset_o [*2] ##1 !uart_full_reset_o;
	endsequence
	property p_wr_ans;
		s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o |-> ##[1:2] s_bvalid_o;
	endproperty
	property p_rd_hold;
		s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o);
	endproperty
	property p_b_hold;
		s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o);
	endproperty
	property p_txf;
		tx_fifo_flush_o |=> !tx_fifo_flush_o;
	endproperty
	property p_rxf;
		rx_fifo_flush_o |=> !rx_fifo_flush_o;
	endproperty
	property p_ur;
		$rose(uart_full_reset_o) |-> s_ur_two;
	endproperty
	property p_dma;
		dma_soft_ack_o |=> !dma_soft_ack_o;
	endproperty
	property p_rts;
		main_wr_rts_i |=> req_to_send_o == $past(main_wdata_i[1]);
	endproperty
	property p_brk;
		main_wr_brk_i |=> break_ctl_o == $past(main_wdata_i[6]);
	endproperty
	property p_fcr;
		main_wr_fcr_i |=> fifo_on_o == $past(main_wdata_i[0]) && dma_select_o == $past(main_wdata_i[3])
			&& rx_threshold_o == $past(main_wdata_i[7:6]);
	endproperty
	property p_halt;
		$changed(tx_halt_o) |-> $rose(s_bvalid_o);
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_txf: assert property (p_txf) else $error("tx flush not a pulse");
	a_rxf: assert property (p_rxf) else $error("rx flush not a pulse");
	a_ur: assert property (p_ur) else $error("full reset width wrong");
	a_dma: assert property (p_dma) else $error("dma ack not a pulse");
	a_rts: assert property (p_rts) else $error("rts main view lost");
	a_brk: assert property (p_brk) else $error("break main view lost");
	a_fcr: assert property (p_fcr) else $error("fifo control view lost");
	a_halt: assert property (p_halt) else $error("halt changed without write");
endmodule
bind uss_regs uss_regs_properties u_props (.mclk_i, .rst_i, .s_awvalid_i, .s_awready_o, .s_wvalid_i,
	.s_wready_o, .s_bvalid_o, .s_bready_i, .s_arvalid_i, .s_arready_o, .s_rvalid_o, .s_rready_i, .s_bresp_o,
	.s_rdata_o, .main_wr_rts_i, .main_wr_brk_i, .main_wr_fcr_i, .main_wdata_i, .req_to_send_o, .break_ctl_o,
	.fifo_on_o, .dma_select_o, .tx_halt_o, .rx_threshold_o, .tx_fifo_flush_o, .rx_fifo_flush_o,
	.uart_full_reset_o, .dma_soft_ack_o);
`default_nettype wire

// file: verif/uss_serial_peer.sv
// Purpose: fifo fill and line activity of the uart core and serial peer
// Assumes: levels loaded by the bench
// Notes: behavioural only
`timescale 1ns/1ps
`default_nettype none
module uss_serial_peer (
	input wire logic mclk_i, rst_i, load_i, tx_flush_i, rx_flush_i, tx_halt_i,
	input wire logic [4:0] tx_set_i, rx_set_i,
	output logic [4:0] tx_level_o, rx_level_o,
	output logic tx_active_o, rx_active_o
);
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || tx_flush_i)
			tx_level_o <= 5'h00;
		else if (load_i)
			tx_level_o <= tx_set_i;
		if (rst_i || rx_flush_i)
			rx_level_o <= 5'h00;
		else if (load_i)
			rx_level_o <= rx_set_i;
	end
	// halted line sends nothing even with data queued
	assign tx_active_o = (tx_level_o != 5'h00) && !tx_halt_i;
	assign rx_active_o = (rx_level_o != 5'h00) && (rx_level_o != 5'h10);
endmodule
`default_nettype wire

// file: verif/uart_status_shadow_regs_tb.sv
// Purpose: self-checking bench for uss_regs
// Assumes: all build options present
// Notes: random shadow data from an lfsr seeded at 6
`include "uss_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_status_shadow_regs_tb;
	logic mclk_i = 1'b0, rst_i = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic mrts = 1'b0, mbrk = 1'b0, mfcr = 1'b0, ld = 1'b0, i0;
	logic [7:0] awa = 8'h00, ara = 8'h00, mwd = 8'h00;
	logic [31:0] wd = 32'h0, d;
	logic [4:0] txs = 5'h00, rxs = 5'h00;
	logic [1:0] rp;
	logic [15:0] lfsr = 16'h0006;
	logic awr, wr, bv, arr, rv, rts, brk, dsel, fon, halt, txf, rxf, ur, dack, irq, tact, ract;
	logic [1:0] bresp, rresp, rxt, txt;
	logic [31:0] rdata;
	logic [4:0] tl, rl;
	int num_errors = 0, n_tests = 0, cyc = 0, nf = 0, nr = 0, nu = 0, nd = 0;
	always #20 mclk_i = ~mclk_i;
	uss_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr),
		.s_wdata_i(wd), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wr), .s_bresp_o(bresp), .s_bvalid_o(bv),
		.s_bready_i(br), .s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rdata),
		.s_rresp_o(rresp), .s_rvalid_o(rv), .s_rready_i(rr), .tx_fifo_level_i(tl), .rx_fifo_level_i(rl),
		.tx_active_i(tact), .rx_active_i(ract), .main_wr_rts_i(mrts), .main_wr_brk_i(mbrk),
		.main_wr_fcr_i(mfcr), .main_wdata_i(mwd), .req_to_send_o(rts), .break_ctl_o(brk), .dma_select_o(dsel),
		.fifo_on_o(fon), .rx_threshold_o(rxt), .tx_empty_threshold_o(txt), .tx_halt_o(halt),
		.tx_fifo_flush_o(txf), .rx_fifo_flush_o(rxf), .uart_full_reset_o(ur), .dma_soft_ack_o(dack), .irq_o(irq));
	uss_serial_peer peer (.mclk_i(mclk_i), .rst_i(rst_i), .load_i(ld), .tx_flush_i(txf), .rx_flush_i(rxf),
		.tx_halt_i(halt), .tx_set_i(txs), .rx_set_i(rxs), .tx_level_o(tl), .rx_level_o(rl),
		.tx_active_o(tact), .rx_active_o(ract));
	// ****************
	// helpers
	// ****************
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] pv(input int k);
		logic [8:0] b;
		b = {halt, txt, rxt, fon, dsel, brk, rts};
		return (k == 4) ? {30'h0, rxt} : (k == 5) ? {30'h0, txt} : {31'h0, b[k + ((k > 5) ? 2 : 0)]};
	endfunction
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!(bv === 1'b1 && !awv && !wv));
		rp = bresp; br <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge mclk_i);
		ara <= a; arv <= 1'b1; rr <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdata; rp = rresp; rr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk($sformatf("reg %h", a), d, e);
	endtask
	task automatic mw(input int w, input logic [7:0] v);
		@(posedge mclk_i);
		mwd <= v; mrts <= (w == 0); mbrk <= (w == 1); mfcr <= (w == 2);
		@(posedge mclk_i);
		mrts <= 1'b0; mbrk <= 1'b0; mfcr <= 1'b0;
	endtask
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1; nf <= nf + txf; nr <= nr + rxf; nu <= nu + ur; nd <= nd + dack;
		// ceiling far above the few hundred cycles of the sequence
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end
	// ****************
	// sequence
	// ****************
	initial
	begin
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		rc(8'h7C, 32'h06);
		rc(8'h80, 32'h0);
		rc(8'h84, 32'h0);
		for (int k = 0; k < 7; k++) rc(8'h8C + 8'(4 * k), 32'h0);
		for (int k = 0; k < 21; k++)
		begin
			lfsr = nx(lfsr);
			axw(8'h8C + 8'(4 * (k % 7)), {16'h0, lfsr});
			rc(8'h8C + 8'(4 * (k % 7)), (k % 7 == 4 || k % 7 == 5) ? {30'h0, lfsr[1:0]} : {31'h0, lfsr[0]});
			chk("shadow port", pv(k % 7), d);
		end
		mw(0, 8'h02);
		rc(8'h8C, 32'h1);
		mw(1, 8'h40);
		rc(8'h90, 32'h1);
		mw(2, 8'hC9);
		rc(8'h98, 32'h1);
		rc(8'h94, 32'h1);
		rc(8'h9C, 32'h3);
		rc(8'hA0, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			lfsr = nx(lfsr);
			@(posedge mclk_i);
			txs <= (k == 1) ? 5'h10 : (k == 2) ? 5'h00 : {1'b0, lfsr[3:0] | 4'h1};
			rxs <= (k == 0) ? 5'h10 : {1'b0, lfsr[7:4]};
			ld <= 1'b1;
			@(posedge mclk_i);
			ld <= 1'b0;
			repeat (3) @(posedge mclk_i);
			rc(8'h80, {27'h0, txs});
			rc(8'h84, {27'h0, rxs});
			rc(8'h7C, {27'h0, rxs == 5'h10, rxs != 5'h00, txs == 5'h00, txs != 5'h10, tact | ract});
		end
		axw(8'h88, 32'h7); repeat (4) @(posedge mclk_i);
		chk("flush count", 32'(nf), 32'h1);
		chk("rx flush count", 32'(nr), 32'h1);
		chk("full reset cycles", 32'(nu), 32'h2);
		rc(8'h80, 32'h0);
		rc(8'h84, 32'h0);
		axw(8'hA8, 32'h1); repeat (2) @(posedge mclk_i);
		chk("dma ack count", 32'(nd), 32'h1);
		rc(8'hE0, 32'h7);
		axw(8'hE4, 32'h0); repeat (2) @(posedge mclk_i); i0 = irq;
		axw(8'hE4, 32'h7); repeat (2) @(posedge mclk_i);
		rc(8'hE4, 32'h7);
		chk("irq mask effect", {31'h0, i0 ^ irq}, 32'h1);
		axw(8'hE0, 32'h7); repeat (2) @(posedge mclk_i);
		chk("irq after clear", {31'h0, irq}, 32'h0);
		rc(8'hE0, 32'h0);
		axr(8'h00);
		chk("unmapped read", {rp, d[29:0]}, 32'h80000000);
		axw(8'h04, 32'h1);
		chk("unmapped write", {30'h0, rp}, 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
